// *** rtl/sfp_array.sv ***
// memory array with self-timed whole-array erase sequencer
`timescale 1ns/1ps
`default_nettype none
module sfp_array #(
  parameter int DEPTH        = 256,
  parameter int ERASE_CYCLES = sfp_pkg::WHOLE_ERASE_TIME_MAX,
  parameter int AW           = $clog2(DEPTH)
) (
  input  wire logic          clock_i,      // system clock
  input  wire logic          rst_n_i,      // synchronous reset, active low
  input  wire logic          start_i,      // one-cycle erase start
  input  wire logic [AW-1:0] peek_addr_i,  // observation address
  output logic               busy_o,       // erase in progress
  output logic               done_o,       // one-cycle erase completion
  output logic [7:0]         peek_data_o   // registered observation data
);

  localparam int CW = $clog2(ERASE_CYCLES + 1);
  localparam logic [CW-1:0] LAST_CNT = CW'(ERASE_CYCLES - 1);
  localparam logic [CW-1:0] DEPTH_C  = CW'(DEPTH);

  if (DEPTH < 2 || DEPTH > ERASE_CYCLES) begin : g_bad_depth
    $error("array depth must be at least 2 and not above the erase cycle count");
  end

  logic [7:0]    mem [DEPTH];
  logic [CW-1:0] cnt;
  logic          erased;

  // sweep writes one byte a cycle; remaining time is pure wait
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      cnt    <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        cnt    <= '0;
      end else if (busy_o) begin
        cnt <= cnt + 1'b1;
        if (cnt == LAST_CNT) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (busy_o && cnt < DEPTH_C) begin
      mem[cnt[AW-1:0]] <= sfp_pkg::ERASED_BYTE;
    end
    peek_data_o <= mem[peek_addr_i];
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      erased <= 1'b0;
    end else if (done_o) begin
      erased <= 1'b1;
    end
  end

  a_erase_fill: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    erased && !busy_o |=> peek_data_o == sfp_pkg::ERASED_BYTE)
    else $error("byte not erased after whole-array erase");

  a_erase_span: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(busy_o) |-> done_o && $past(cnt) == LAST_CNT)
    else $error("erase ended at the wrong count");

endmodule
`default_nettype wire

// *** rtl/sfp_cmd_ctrl.sv ***
// serial flash command logic: erase, status, write latch, protection, identification
//
// Overview of operation
// - whole-array erase writes FFH into every byte of the memory.
// - whole-array erase is discarded while any block protection level bit is set.
// - opcode 60H with select low; erase begins only when select rises.
// - whole-array erase is refused while the write enable latch is clear.
// - self-timed whole-array erase lasts at most 100 ms; busy reflects it.
// - status read is accepted at any time, even during an erase.
// - status read repeats the current status byte until select rises.
// - set-write command sets the write enable latch when select rises.
// - clear-write command clears latch at select rise, and auto-increment flag unless a session start pulses in that cycle.
// - arming opens status for one write only if the next command writes.
// - armed status write changes only both level bits and the lock bit.
// - status write ignored when protect pin low and lock bit set.
// - with protect pin low the lock bit may only go from 0 to 1.
// - lock 0 or protect pin high: all three protection bits update together.
// - opcode 90H or ABH plus 24-bit address reads maker or part code.
// - identification output alternates maker and part code until select rises.
// - clear-write opcode is 04H and also ends auto-increment programming.
// - every command, address or data unit is exactly eight serial clocks.
// - bytes travel most significant bit first, bit 7 down to bit 0.
`timescale 1ns/1ps
`default_nettype none
module sfp_cmd_ctrl #(
  parameter int         ERASE_CYCLES = sfp_pkg::WHOLE_ERASE_TIME_MAX,
  parameter int         ARRAY_DEPTH  = 256,
  parameter logic [7:0] MAKER_CODE   = sfp_pkg::MAKER_CODE_DEF,
  parameter logic [7:0] PART_CODE    = sfp_pkg::PART_CODE_DEF,
  parameter int         AW           = $clog2(ARRAY_DEPTH)
) (
  input  wire logic          clock_i,      // system clock, 50 MHz
  input  wire logic          rst_n_i,      // synchronous reset, active low
  input  wire logic          cs_n_i,       // chip select pin, active low
  input  wire logic          sck_i,        // serial clock pin
  input  wire logic          si_i,         // serial data in pin
  input  wire logic          wp_n_i,       // write protect pin, active low
  input  wire logic          aai_set_i,    // pulse: auto-increment session began
  input  wire logic [AW-1:0] peek_addr_i,  // array observation address
  output logic               so_o,         // serial data out
  output logic               so_oe_o,      // serial data out drive enable
  output sfp_pkg::sfp_status_s status_o,   // status register
  output logic [7:0]         peek_data_o   // array observation data
);

  if (ERASE_CYCLES < 2) begin : g_bad_cycles
    $error("erase cycle count must be at least 2");
  end

  sfp_pkg::sfp_link_s  link_raw;
  sfp_pkg::sfp_link_s  link_s;
  sfp_pkg::sfp_status_s status_q;
  sfp_pkg::sfp_status_s wdata_s;
  sfp_pkg::sfp_state_e state;

  logic       sck_d;
  logic       cs_d;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic [2:0] bit_cnt;
  logic [6:0] in_sh;
  logic [7:0] rx_byte;
  logic       byte_done;
  logic [7:0] opcode;
  logic [1:0] addr_cnt;
  logic       overrun;
  logic [7:0] wdata;
  logic       armed;
  logic       ident_sel;
  logic [2:0] out_cnt;
  logic [6:0] out_sh;
  logic [7:0] out_byte;
  logic       out_phase;
  logic       exec_ok;
  logic       do_erase;
  logic       do_set_wel;
  logic       do_clr_wel;
  logic       do_arm;
  logic       do_wrstat;
  logic       protected_any;
  logic       locked;
  logic       erase_done;
  logic       array_busy;

  assign link_raw = '{cs_n: cs_n_i, sck: sck_i, si: si_i, wp_n: wp_n_i};

  sfp_sync #(
    .W       ($bits(sfp_pkg::sfp_link_s)),
    .RST_VAL (sfp_pkg::LINK_IDLE)
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .d_i     (link_raw),
    .q_o     (link_s)
  );

  // edge detection on the synchronised pins
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sck_d <= link_s.sck;
      cs_d  <= link_s.cs_n;
    end
  end

  assign sck_rise = link_s.sck & ~sck_d & ~link_s.cs_n;
  assign sck_fall = ~link_s.sck & sck_d & ~link_s.cs_n;
  assign cs_rise  = link_s.cs_n & ~cs_d;

  // input shifter, sampled on the serial clock rising edge
  assign rx_byte   = {in_sh, link_s.si};
  assign byte_done = sck_rise && (bit_cnt == 3'h7);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || link_s.cs_n) begin
      bit_cnt <= 3'h0;
      in_sh   <= 7'h00;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      in_sh   <= {in_sh[5:0], link_s.si};
    end
  end

  // command sequencer; deselect always returns it to opcode reception
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || link_s.cs_n) begin
      state    <= sfp_pkg::ST_OPCODE;
      opcode   <= 8'h00;
      addr_cnt <= 2'h0;
      overrun  <= 1'b0;
      wdata    <= 8'h00;
    end else if (byte_done) begin
      unique case (state)
        sfp_pkg::ST_OPCODE: begin
          opcode <= rx_byte;
          if (rx_byte == sfp_pkg::OP_STATUS_READ) begin
            state <= sfp_pkg::ST_STATUS_OUT;
          end else if (status_q.busy) begin
            state <= sfp_pkg::ST_DONE;
          end else if (rx_byte == sfp_pkg::OP_IDENT_READ_A ||
                       rx_byte == sfp_pkg::OP_IDENT_READ_B) begin
            state <= sfp_pkg::ST_ADDR;
          end else if (rx_byte == sfp_pkg::OP_STATUS_WRITE) begin
            state <= sfp_pkg::ST_WDATA;
          end else begin
            state <= sfp_pkg::ST_DONE;
          end
        end
        sfp_pkg::ST_ADDR: begin
          addr_cnt <= addr_cnt + 2'h1;
          if (addr_cnt == 2'(sfp_pkg::ADDR_BYTES - 1)) begin
            state <= sfp_pkg::ST_IDENT_OUT;
          end
        end
        sfp_pkg::ST_WDATA: begin
          wdata <= rx_byte;
          state <= sfp_pkg::ST_DONE;
        end
        sfp_pkg::ST_DONE: begin
          overrun <= 1'b1;
        end
        sfp_pkg::ST_STATUS_OUT,
        sfp_pkg::ST_IDENT_OUT: begin
          state <= state;
        end
      endcase
    end
  end

  // execution happens only on the select rising edge of a whole command
  assign exec_ok = cs_rise && (state == sfp_pkg::ST_DONE) && (bit_cnt == 3'h0) &&
                   !overrun && !status_q.busy;
  assign protected_any = status_q.protect_level_bit_hi | status_q.protect_level_bit_lo;
  assign locked        = !link_s.wp_n && status_q.protect_lock_bit;
  assign wdata_s       = sfp_pkg::sfp_status_s'(wdata);

  assign do_erase   = exec_ok && (opcode == sfp_pkg::OP_WHOLE_ERASE) &&
                      status_q.write_enable_latch &&
                      !protected_any;
  assign do_set_wel = exec_ok && (opcode == sfp_pkg::OP_SET_WRITE);
  assign do_clr_wel = exec_ok && (opcode == sfp_pkg::OP_CLEAR_WRITE);
  assign do_arm     = exec_ok && (opcode == sfp_pkg::OP_STATUS_ARM);
  assign do_wrstat  = exec_ok && (opcode == sfp_pkg::OP_STATUS_WRITE) &&
                      armed &&
                      !locked;

  // any command ending, written or not, consumes the arming
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      armed <= 1'b0;
    end else if (cs_rise) begin
      armed <= do_arm;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_q.busy <= 1'b0;
    end else if (do_erase) begin
      status_q.busy <= 1'b1;
    end else if (erase_done) begin
      status_q.busy <= 1'b0;
    end
  end

  // set-write is ignored while busy, so it never meets the completion clear
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_q.write_enable_latch <= 1'b0;
    end else if (do_set_wel) begin
      status_q.write_enable_latch <= 1'b1;
    end else if (do_clr_wel || erase_done) begin
      status_q.write_enable_latch <= 1'b0;
    end
  end

  // a session start arriving with the clear is kept
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_q.auto_increment_program_flag <= 1'b0;
    end else if (aai_set_i) begin
      status_q.auto_increment_program_flag <= 1'b1;
    end else if (do_clr_wel) begin
      status_q.auto_increment_program_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_q.protect_lock_bit     <= 1'b0;
      status_q.protect_level_bit_hi <= 1'b0;
      status_q.protect_level_bit_lo <= 1'b0;
      status_q.spare                <= 2'h0;
    end else if (do_wrstat) begin
      status_q.protect_level_bit_hi <= wdata_s.protect_level_bit_hi;
      status_q.protect_level_bit_lo <= wdata_s.protect_level_bit_lo;
      if (link_s.wp_n) begin
        status_q.protect_lock_bit <= wdata_s.protect_lock_bit;
      end else begin
        status_q.protect_lock_bit <= status_q.protect_lock_bit |
                                     wdata_s.protect_lock_bit;
      end
    end
  end

  assign status_o = status_q;

  // output shifter, driven after the serial clock falling edge
  assign out_phase = (state == sfp_pkg::ST_STATUS_OUT) || (state == sfp_pkg::ST_IDENT_OUT);
  assign out_byte  = (state == sfp_pkg::ST_STATUS_OUT) ? status_q :
                     (ident_sel ? PART_CODE : MAKER_CODE);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || link_s.cs_n) begin
      so_o    <= 1'b0;
      so_oe_o <= 1'b0;
      out_cnt <= 3'h0;
      out_sh  <= 7'h00;
    end else if (sck_fall && out_phase) begin
      so_oe_o <= 1'b1;
      out_cnt <= out_cnt + 3'h1;
      if (out_cnt == 3'h0) begin
        so_o   <= out_byte[7];
        out_sh <= out_byte[6:0];
      end else begin
        so_o   <= out_sh[6];
        out_sh <= {out_sh[5:0], 1'b0};
      end
    end
  end

  // low address bit picks the first code; each finished byte swaps
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ident_sel <= 1'b0;
    end else if (byte_done && state == sfp_pkg::ST_ADDR) begin
      ident_sel <= rx_byte[0];
    end else if (sck_fall && state == sfp_pkg::ST_IDENT_OUT && out_cnt == 3'h7) begin
      ident_sel <= ~ident_sel;
    end
  end

  sfp_array #(
    .DEPTH        (ARRAY_DEPTH),
    .ERASE_CYCLES (ERASE_CYCLES)
  ) u_array (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .start_i     (do_erase),
    .peek_addr_i (peek_addr_i),
    .busy_o      (array_busy),
    .done_o      (erase_done),
    .peek_data_o (peek_data_o)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_erase_guard: assert property (do_erase |-> !protected_any)
    else $error("erase started while protected");

  a_erase_latch: assert property (do_erase |-> status_q.write_enable_latch)
    else $error("erase started without write enable");

  a_erase_on_rise: assert property (
    $rose(status_q.busy) |-> $past(cs_rise) && $past(opcode) == sfp_pkg::OP_WHOLE_ERASE)
    else $error("erase began without select rising");

  a_busy_end: assert property (
    $fell(status_q.busy) |-> !status_q.write_enable_latch && !array_busy)
    else $error("busy cleared without clearing write latch");

  a_status_loop: assert property (
    state == sfp_pkg::ST_STATUS_OUT && !link_s.cs_n |=> state == sfp_pkg::ST_STATUS_OUT)
    else $error("status read stopped while selected");

  a_status_msb: assert property (
    sck_fall && state == sfp_pkg::ST_STATUS_OUT && out_cnt == 3'h0
    |=> so_o == $past(status_q.protect_lock_bit) && so_oe_o)
    else $error("status byte not sent msb first");

  a_set_latch: assert property (do_set_wel |=> status_q.write_enable_latch)
    else $error("set-write did not set latch");

  a_clear_latch: assert property (
    do_clr_wel && !aai_set_i |=> !status_q.write_enable_latch &&
    !status_q.auto_increment_program_flag)
    else $error("clear-write left latch or flag set");

  a_lock_hold: assert property (
    !link_s.wp_n && status_q.protect_lock_bit && $stable(link_s.wp_n)
    |=> status_q.protect_lock_bit)
    else $error("lock bit released while protect pin low");

  a_locked_skip: assert property (
    cs_rise && locked |=> $stable({status_q.protect_lock_bit,
    status_q.protect_level_bit_hi, status_q.protect_level_bit_lo}))
    else $error("locked status register changed");

  a_arm_lapse: assert property (
    cs_rise && !armed |=> $stable({status_q.protect_level_bit_hi,
    status_q.protect_level_bit_lo}))
    else $error("status written without arming");

  a_ident_swap: assert property (
    sck_fall && state == sfp_pkg::ST_IDENT_OUT && out_cnt == 3'h7
    |=> ident_sel != $past(ident_sel))
    else $error("identification code did not alternate");

  c_erase_start: cover property (do_erase);
  c_status_busy: cover property (status_q.busy && byte_done && state == sfp_pkg::ST_OPCODE &&
                                 rx_byte == sfp_pkg::OP_STATUS_READ);
  c_ident_swap: cover property (state == sfp_pkg::ST_IDENT_OUT && sck_fall && out_cnt == 3'h7);
  c_lock_set: cover property (do_wrstat && !link_s.wp_n && wdata_s.protect_lock_bit);

endmodule
`default_nettype wire

// *** rtl/sfp_pkg.sv ***
// shared constants, opcodes and types of the serial flash protection command logic
package sfp_pkg;

  // system clock and self-timed whole-array erase
  localparam int CLK_HZ              = 50_000_000;
  localparam int WHOLE_ERASE_TIME_MS = 100;
  // longest time: integer division rounds down
  localparam int WHOLE_ERASE_TIME_MAX = (CLK_HZ / 1000) * WHOLE_ERASE_TIME_MS;

  // serial framing
  localparam int BYTE_BITS  = 8;
  localparam int ADDR_BYTES = 3;

  // opcodes
  localparam logic [7:0] OP_WHOLE_ERASE   = 8'h60;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_SET_WRITE     = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE   = 8'h04;
  localparam logic [7:0] OP_STATUS_ARM    = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_IDENT_READ_A  = 8'h90;
  localparam logic [7:0] OP_IDENT_READ_B  = 8'hAB;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // identification codes: both values are arbitrary
  localparam logic [7:0] MAKER_CODE_DEF = 8'h5A;
  localparam logic [7:0] PART_CODE_DEF  = 8'hC3;

  // status byte, bit 7 down to bit 0
  typedef struct packed {
    logic       protect_lock_bit;
    logic       auto_increment_program_flag;
    logic [1:0] spare;
    logic       protect_level_bit_hi;
    logic       protect_level_bit_lo;
    logic       write_enable_latch;
    logic       busy;
  } sfp_status_s;

  localparam sfp_status_s STATUS_RESET = sfp_status_s'(8'h00);

  // serial pins as they arrive from the host
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } sfp_link_s;

  // idle levels: deselected, serial clock low, write protect released
  localparam sfp_link_s LINK_IDLE = sfp_link_s'(4'h9);

  typedef enum logic [2:0] {
    ST_OPCODE     = 3'b000,
    ST_ADDR       = 3'b001,
    ST_WDATA      = 3'b010,
    ST_STATUS_OUT = 3'b011,
    ST_IDENT_OUT  = 3'b100,
    ST_DONE       = 3'b101
  } sfp_state_e;

endpackage

// *** rtl/sfp_sync.sv ***
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfp_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clock_i,  // system clock
  input  wire logic         rst_n_i,  // synchronous reset, active low
  input  wire logic [W-1:0] d_i,      // asynchronous inputs
  output logic      [W-1:0] q_o       // synchronised outputs
);

  logic [W-1:0] meta;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule
`default_nettype wire

// *** testbench/sfp_host_model.sv ***
// serial host model: drives select, serial clock and data in, gathers data out
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
  input  wire logic clock_i,  // system clock, paces the serial clock
  input  wire logic so_i,     // serial data out of the device
  output logic      cs_n_o,   // chip select, active low
  output logic      sck_o,    // serial clock, idle low between frames
  output logic      si_o      // serial data in
);
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  // four system clocks make one half of the 160 ns serial period
  task automatic half();
    repeat (4) @(negedge clock_i);
  endtask

  task automatic deselect();
    cs_n_o = 1'b1;
    repeat (8) @(negedge clock_i);
  endtask

  // shifts n bits of tx from bit 63 down; keep leaves select low afterwards
  task automatic xfer(input logic [63:0] tx, input int n, input bit keep,
                      output logic [63:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      si_o = tx[63-i];
      half();
      sck_o = 1'b1;
      half();
      // sampled late in the high phase: output only moves after a fall
      rx = {rx[62:0], so_i};
      sck_o = 1'b0;
    end
    half();
    si_o = ~si_o; // released line must not keep its last value
    if (!keep) begin
      deselect();
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench of the serial flash command logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int         ERASE = 600;
  localparam int         DEPTH = 16;
  localparam logic [7:0] MAKER = 8'h3C;  // arbitrary value
  localparam logic [7:0] PART  = 8'h96;  // arbitrary value
  localparam int         LIMIT = 40000;

  logic                 clock = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 cs_n;
  logic                 sck;
  logic                 si;
  logic                 wp_n = 1'b1;
  logic                 aai_set = 1'b0;
  logic [3:0]           peek_addr = 4'h0;
  logic                 so;
  logic                 so_oe;
  sfp_pkg::sfp_status_s status;
  logic [7:0]           peek_data;
  logic [63:0]          rx;
  int                   error_cnt = 0;
  int                   cmp_count = 0;
  int                   cycles = 0;

  always #10 clock = ~clock;

  sfp_cmd_ctrl #(.ERASE_CYCLES(ERASE), .ARRAY_DEPTH(DEPTH), .MAKER_CODE(MAKER),
                 .PART_CODE(PART)) i_sfp_cmd_ctrl (
    .clock_i(clock), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .wp_n_i(wp_n), .aai_set_i(aai_set), .peek_addr_i(peek_addr), .so_o(so),
    .so_oe_o(so_oe), .status_o(status), .peek_data_o(peek_data));

  sfp_host_model i_sfp_host_model (
    .clock_i(clock), .so_i(so), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic [63:0] tx, input int n);
    i_sfp_host_model.xfer(tx, n, 1'b0, rx);
  endtask

  task automatic op(input logic [7:0] c);
    cmd({c, 56'h0}, 8);
  endtask

  task automatic wstat(input logic [7:0] d);
    op(sfp_pkg::OP_STATUS_ARM);
    cmd({sfp_pkg::OP_STATUS_WRITE, d, 48'h0}, 16);
  endtask

  task automatic st(input logic [7:0] exp);
    check("status", {8'h00, exp}, {8'h00, status});
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    st(8'h00);
    check("drive enable", 16'h0000, {15'h0, so_oe});
    op(sfp_pkg::OP_SET_WRITE);
    st(8'h02);
    aai_set = 1'b1;
    @(negedge clock);
    aai_set = 1'b0;
    @(negedge clock);
    st(8'h42);
    op(sfp_pkg::OP_CLEAR_WRITE);
    st(8'h00);
    cmd({sfp_pkg::OP_SET_WRITE, 56'h0}, 7);
    st(8'h00);
    // one byte too many also voids the command
    cmd({sfp_pkg::OP_SET_WRITE, 8'h00, 48'h0}, 16);
    st(8'h00);
    op(sfp_pkg::OP_WHOLE_ERASE);
    st(8'h00);
    cmd({sfp_pkg::OP_STATUS_WRITE, 8'h0C, 48'h0}, 16);
    st(8'h00);
    op(sfp_pkg::OP_STATUS_ARM);
    op(sfp_pkg::OP_STATUS_READ);
    cmd({sfp_pkg::OP_STATUS_WRITE, 8'h0C, 48'h0}, 16);
    st(8'h00);
    op(sfp_pkg::OP_SET_WRITE);
    wstat(8'hFF);
    st(8'h8E);
    op(sfp_pkg::OP_WHOLE_ERASE);
    st(8'h8E);
    wp_n = 1'b0;
    wstat(8'h00);
    st(8'h8E);
    wp_n = 1'b1;
    wstat(8'h00);
    st(8'h02);
    wp_n = 1'b0;
    wstat(8'h8C);
    st(8'h8E);
    wp_n = 1'b1;
    wstat(8'h00);
    st(8'h02);
    // erase: nothing may start while select is still low
    i_sfp_host_model.xfer({sfp_pkg::OP_WHOLE_ERASE, 56'h0}, 8, 1'b1, rx);
    repeat (12) @(negedge clock);
    st(8'h02);
    i_sfp_host_model.deselect();
    st(8'h03);
    // busy refuses everything but the status read
    op(sfp_pkg::OP_CLEAR_WRITE);
    st(8'h03);
    i_sfp_host_model.xfer({sfp_pkg::OP_STATUS_READ, 56'h0}, 24, 1'b1, rx);
    check("drive enable", 16'h0001, {15'h0, so_oe});
    i_sfp_host_model.deselect();
    check("status stream", 16'h0303, rx[15:0]);
    check("drive enable", 16'h0000, {15'h0, so_oe});
    // polling busy bounds the self-timed erase
    for (int i = 0; i < ERASE && status.busy !== 1'b0; i++) begin
      @(negedge clock);
    end
    st(8'h00);
    for (int a = 0; a < DEPTH; a++) begin
      peek_addr = 4'(a);
      repeat (2) @(negedge clock);
      check("array byte", 16'h00FF, {8'h00, peek_data});
    end
    i_sfp_host_model.xfer({sfp_pkg::OP_IDENT_READ_A, 24'h0, 32'h0}, 48, 1'b0, rx);
    check("ident", {MAKER, PART}, rx[15:0]);
    i_sfp_host_model.xfer({sfp_pkg::OP_IDENT_READ_B, 24'h1, 32'h0}, 48, 1'b0, rx);
    check("ident", {PART, MAKER}, rx[15:0]);
    end_of_test();
  end
endmodule
`default_nettype wire
